// file: include/asle_pkg.sv
package asle_pkg;

    // Clock and timing base
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int FLASH_HALF_MS = 500;
    localparam int ACT_HALF_MS = 50;
    localparam int FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_FREQ_HZ / 1000);
    localparam int ACT_HALF_CYC = ACT_HALF_MS * (CLK_FREQ_HZ / 1000);

    // Depth of the timed-out connection count
    localparam int TMO_CNT_W = 8;

    // Register map (byte addresses)
    localparam int APB_ADDR_W = 12;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_INT_STAT = 12'h008;
    localparam logic [11:0] OFF_INT_MASK = 12'h00C;

    // Control register fields and reset value
    localparam int CTRL_LED_EN_BIT = 0;
    localparam logic CTRL_LED_EN_RST = 1'b1;

    // Status register fields
    localparam int STAT_MS_LSB = 0;
    localparam int STAT_NS_LSB = 3;
    localparam int STAT_LINK_BIT = 6;
    localparam int STAT_ACT_BIT = 7;
    localparam int STAT_TMO_BIT = 8;
    localparam int STAT_CNT_LSB = 16;
    localparam int STAT_CNT_MAX_W = 16;

    // Interrupt status and mask layout
    localparam int INT_W = 5;
    localparam int INT_MAJOR = 0;
    localparam int INT_MINOR = 1;
    localparam int INT_DUP_IP = 2;
    localparam int INT_TMO = 3;
    localparam int INT_LINK = 4;
    localparam logic [INT_W-1:0] INT_STAT_RST = 5'h00;
    localparam logic [INT_W-1:0] INT_MASK_RST = 5'h00;

    // Indication modes of a two-colour LED
    typedef enum logic [2:0] {
        MODE_OFF = 3'b000,
        MODE_GRN_ON = 3'b001,
        MODE_GRN_FL = 3'b010,
        MODE_RED_ON = 3'b011,
        MODE_RED_FL = 3'b100,
        MODE_ALT = 3'b101
    } asle_mode_t;

    // Two-colour LED drive
    typedef struct packed {
        logic red;
        logic green;
    } asle_duo_t;

    // Condition levels and events from the protocol stack
    typedef struct packed {
        logic self_test;
        logic configured;
        logic major_fault;
        logic minor_fault;
        logic config_error;
        logic ip_valid;
        logic dup_ip;
        logic conn_up;
        logic conn_timeout_evt;
        logic conn_restore_evt;
    } asle_stack_t;

    // Turn a mode into lamp levels for the current flash phase
    function automatic asle_duo_t asle_render(asle_mode_t mode, logic phase);
        asle_duo_t d;
        d = '{red: 1'b0, green: 1'b0};
        unique case (mode)
            MODE_OFF: d = '{red: 1'b0, green: 1'b0};
            MODE_GRN_ON: d = '{red: 1'b0, green: 1'b1};
            MODE_GRN_FL: d = '{red: 1'b0, green: phase};
            MODE_RED_ON: d = '{red: 1'b1, green: 1'b0};
            MODE_RED_FL: d = '{red: phase, green: 1'b0};
            MODE_ALT: d = '{red: ~phase, green: phase};
            default: d = '{red: 1'b0, green: 1'b0};
        endcase
        return d;
    endfunction

endpackage

// file: rtl/asle_flash_gen.sv
module asle_flash_gen #(
    parameter int HALF_CYC = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic phase,
    output logic tick
);
    import asle_pkg::*;

    localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;

    if (HALF_CYC < 2) begin : g_bad_half
        $error("asle_flash_gen: HALF_CYC must be at least 2");
    end

    logic [CW-1:0] cnt_r, cnt_nxt;
    logic phase_r, phase_nxt;
    logic tick_r, tick_nxt;

    always_comb begin
        cnt_nxt = cnt_r + CW'(1);
        phase_nxt = phase_r;
        tick_nxt = 1'b0;
        if (cnt_r == CW'(HALF_CYC - 1)) begin
            cnt_nxt = '0;
            phase_nxt = ~phase_r;
            tick_nxt = 1'b1;
        end
    end

    // Free-running, so every LED flashing at this rate stays in step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            phase_r <= 1'b0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            phase_r <= phase_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign phase = phase_r;
    assign tick = tick_r;

    a_phase_tick: assert property (@(posedge pclk) disable iff (!presetn) $changed(phase_r) |-> tick_r)
        else $error("Flash phase changed without a tick");

endmodule // asle_flash_gen

// file: rtl/asle_top.sv
module asle_top #(
    parameter int FLASH_HALF_CYC = asle_pkg::FLASH_HALF_CYC,
    parameter int ACT_HALF_CYC = asle_pkg::ACT_HALF_CYC,
    parameter int TMO_CNT_W = asle_pkg::TMO_CNT_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [asle_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input asle_pkg::asle_stack_t stack_status,
    input wire logic phy_link,
    input wire logic phy_activity,
    output asle_pkg::asle_duo_t module_status_led,
    output asle_pkg::asle_duo_t network_status_led,
    output logic port_link_led,
    output logic port_activity_led,
    output logic irq
);
    import asle_pkg::*;

    // Refuse sizes the logic cannot serve
    if (TMO_CNT_W < 1 || TMO_CNT_W > STAT_CNT_MAX_W) begin : g_bad_cnt
        $error("asle_top: TMO_CNT_W out of range");
    end

    localparam logic [INT_W-1:0] INT_BOTH_EDGES = INT_W'(1) << INT_LINK;

    function automatic asle_mode_t pick_ms(asle_stack_t s);
        asle_mode_t m;
        m = MODE_GRN_ON;
        if (s.self_test) begin
            m = MODE_ALT;
        end else if (s.major_fault) begin
            m = MODE_RED_ON;
        end else if (s.minor_fault || s.config_error) begin
            m = MODE_RED_FL;
        end else if (!s.configured) begin
            m = MODE_GRN_FL;
        end
        return m;
    endfunction

    function automatic asle_mode_t pick_ns(asle_stack_t s, logic tmo);
        asle_mode_t m;
        m = MODE_GRN_FL;
        if (s.self_test) begin
            m = MODE_ALT;
        end else if (!s.ip_valid) begin
            m = MODE_OFF;
        end else if (s.dup_ip) begin
            m = MODE_RED_ON;
        end else if (tmo) begin
            m = MODE_RED_FL;
        end else if (s.conn_up) begin
            m = MODE_GRN_ON;
        end
        return m;
    endfunction

    // Two-stage synchronisers for the PHY pins
    logic [1:0] link_sync_r, link_sync_nxt;
    logic [1:0] act_sync_r, act_sync_nxt;
    logic link_s, act_s;

    always_comb begin
        link_sync_nxt = {link_sync_r[0], phy_link};
        act_sync_nxt = {act_sync_r[0], phy_activity};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_sync_r <= 2'h0;
            act_sync_r <= 2'h0;
        end else begin
            link_sync_r <= link_sync_nxt;
            act_sync_r <= act_sync_nxt;
        end
    end

    assign link_s = link_sync_r[1];
    assign act_s = act_sync_r[1];

    // slow flash and fast activity blink
    logic slow_phase, fast_phase, fast_tick;

    asle_flash_gen #(.HALF_CYC(FLASH_HALF_CYC)) u_slow (
        .pclk(pclk),
        .presetn(presetn),
        .phase(slow_phase),
        .tick()
    );

    asle_flash_gen #(.HALF_CYC(ACT_HALF_CYC)) u_fast (
        .pclk(pclk),
        .presetn(presetn),
        .phase(fast_phase),
        .tick(fast_tick)
    );

    // Count of timed-out connections; saturates so it never wraps to zero
    logic [TMO_CNT_W-1:0] tmo_cnt_r, tmo_cnt_nxt;
    logic tmo_active;

    always_comb begin
        tmo_cnt_nxt = tmo_cnt_r;
        if (stack_status.conn_timeout_evt && !stack_status.conn_restore_evt) begin
            if (tmo_cnt_r != '1) begin
                tmo_cnt_nxt = tmo_cnt_r + TMO_CNT_W'(1);
            end
        end else if (stack_status.conn_restore_evt && !stack_status.conn_timeout_evt) begin
            if (tmo_cnt_r != '0) begin
                tmo_cnt_nxt = tmo_cnt_r - TMO_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmo_cnt_r <= '0;
        end else begin
            tmo_cnt_r <= tmo_cnt_nxt;
        end
    end

    assign tmo_active = (tmo_cnt_r != '0);

    // Event detection: rising fault conditions and any link change
    logic [INT_W-1:0] cond_now, cond_prev_r, evt;

    always_comb begin
        cond_now = '0;
        cond_now[INT_MAJOR] = stack_status.major_fault;
        cond_now[INT_MINOR] = stack_status.minor_fault | stack_status.config_error;
        cond_now[INT_DUP_IP] = stack_status.dup_ip;
        cond_now[INT_TMO] = tmo_active;
        cond_now[INT_LINK] = link_s;
        evt = (cond_now & ~cond_prev_r) | (INT_BOTH_EDGES & (cond_now ^ cond_prev_r));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cond_prev_r <= '0;
        end else begin
            cond_prev_r <= cond_now;
        end
    end

    // Mode selection and lamp rendering; all lamps go dark with the enable off
    asle_mode_t ms_mode, ns_mode;
    logic led_en_r, led_en_nxt;
    asle_duo_t ms_led_r, ms_led_nxt, ns_led_r, ns_led_nxt;
    logic link_led_r, link_led_nxt, act_led_r, act_led_nxt;
    logic act_acc_r, act_acc_nxt, act_show_r, act_show_nxt;

    always_comb begin
        ms_mode = pick_ms(stack_status);
        ns_mode = pick_ns(stack_status, tmo_active);
        ms_led_nxt = led_en_r ? asle_render(ms_mode, slow_phase) : asle_duo_t'(2'b00);
        ns_led_nxt = led_en_r ? asle_render(ns_mode, slow_phase) : asle_duo_t'(2'b00);
        link_led_nxt = led_en_r & link_s;
        act_acc_nxt = fast_tick ? 1'b0 : (act_acc_r | act_s);
        act_show_nxt = fast_tick ? (act_acc_r | act_s) : act_show_r;
        act_led_nxt = led_en_r & act_show_r & fast_phase;
    end

    // Short frames are stretched to one blink window so they stay visible
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_led_r <= '{red: 1'b0, green: 1'b0};
            ns_led_r <= '{red: 1'b0, green: 1'b0};
            link_led_r <= 1'b0;
            act_led_r <= 1'b0;
            act_acc_r <= 1'b0;
            act_show_r <= 1'b0;
        end else begin
            ms_led_r <= ms_led_nxt;
            ns_led_r <= ns_led_nxt;
            link_led_r <= link_led_nxt;
            act_led_r <= act_led_nxt;
            act_acc_r <= act_acc_nxt;
            act_show_r <= act_show_nxt;
        end
    end

    // APB slave: no wait states; read data and ready are flopped from the setup cycle
    logic [INT_W-1:0] int_stat_r, int_stat_nxt, int_mask_r, int_mask_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_r, irq_nxt;
    logic setup, wr_commit;
    logic [INT_W-1:0] w1c;

    always_comb begin
        setup = psel & ~penable;
        wr_commit = psel & penable & pready_r & pwrite;
        led_en_nxt = led_en_r;
        int_mask_nxt = int_mask_r;
        w1c = '0;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        pready_nxt = setup;
        if (wr_commit) begin
            unique case (paddr)
                OFF_CTRL: led_en_nxt = pwdata[CTRL_LED_EN_BIT];
                OFF_INT_STAT: w1c = pwdata[INT_W-1:0];
                OFF_INT_MASK: int_mask_nxt = pwdata[INT_W-1:0];
                default: ;
            endcase
        end
        if (setup) begin
            prdata_nxt = '0;
            unique case (paddr)
                OFF_CTRL: prdata_nxt[CTRL_LED_EN_BIT] = led_en_r;
                OFF_STATUS: begin
                    prdata_nxt[STAT_MS_LSB +: 3] = ms_mode;
                    prdata_nxt[STAT_NS_LSB +: 3] = ns_mode;
                    prdata_nxt[STAT_LINK_BIT] = link_s;
                    prdata_nxt[STAT_ACT_BIT] = act_show_r;
                    prdata_nxt[STAT_TMO_BIT] = tmo_active;
                    prdata_nxt[STAT_CNT_LSB +: TMO_CNT_W] = tmo_cnt_r;
                end
                OFF_INT_STAT: prdata_nxt[INT_W-1:0] = int_stat_r;
                OFF_INT_MASK: prdata_nxt[INT_W-1:0] = int_mask_r;
                default: pslverr_nxt = 1'b1;
            endcase
        end
        // A new event beats a clear in the same cycle
        int_stat_nxt = (int_stat_r & ~w1c) | evt;
        irq_nxt = |(int_stat_nxt & int_mask_nxt);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            led_en_r <= CTRL_LED_EN_RST;
            int_stat_r <= INT_STAT_RST;
            int_mask_r <= INT_MASK_RST;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            led_en_r <= led_en_nxt;
            int_stat_r <= int_stat_nxt;
            int_mask_r <= int_mask_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign module_status_led = ms_led_r;
    assign network_status_led = ns_led_r;
    assign port_link_led = link_led_r;
    assign port_activity_led = act_led_r;
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;

    // Checks on the lamp encoding and the bus answer; sampled presetn skips the release edge, lamps still at reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ms_run_green: assert property (presetn && led_en_r && !stack_status.self_test
        && !stack_status.major_fault && !stack_status.minor_fault && !stack_status.config_error
        && stack_status.configured |=> module_status_led == asle_duo_t'{red: 1'b0, green: 1'b1})
        else $error("Module LED not steady green when operational");
    a_ms_standby_flash: assert property (led_en_r && !stack_status.self_test && !stack_status.major_fault
        && !stack_status.minor_fault && !stack_status.config_error && !stack_status.configured
        |=> !module_status_led.red && module_status_led.green == $past(slow_phase))
        else $error("Module LED not flashing green in standby");
    a_ms_major_red: assert property (presetn && led_en_r && !stack_status.self_test
        && stack_status.major_fault |=> module_status_led == asle_duo_t'{red: 1'b1, green: 1'b0})
        else $error("Module LED not steady red on major fault");
    a_ms_minor_flash: assert property (led_en_r && !stack_status.self_test && !stack_status.major_fault
        && stack_status.config_error |=> !module_status_led.green && module_status_led.red == $past(slow_phase))
        else $error("Module LED not flashing red on minor fault");
    a_ms_selftest_alt: assert property (presetn && led_en_r && stack_status.self_test
        |=> module_status_led.red != module_status_led.green)
        else $error("Module LED not alternating in self-test");
    a_ns_conn_green: assert property (presetn && led_en_r && !stack_status.self_test && stack_status.ip_valid
        && !stack_status.dup_ip && !tmo_active && stack_status.conn_up
        |=> network_status_led == asle_duo_t'{red: 1'b0, green: 1'b1})
        else $error("Network LED not steady green when connected");
    a_ns_dup_red: assert property (presetn && led_en_r && !stack_status.self_test && stack_status.ip_valid
        && stack_status.dup_ip |=> network_status_led == asle_duo_t'{red: 1'b1, green: 1'b0})
        else $error("Network LED not steady red on duplicate address");
    a_ns_tmo_flash: assert property (led_en_r && !stack_status.self_test && stack_status.ip_valid
        && !stack_status.dup_ip && tmo_active |=> !network_status_led.green)
        else $error("Network LED shows green during connection timeout");
    a_tmo_hold_until: assert property (tmo_active && !stack_status.conn_restore_evt |=> tmo_active)
        else $error("Timeout indication cleared without re-establishment");
    a_ns_selftest_alt: assert property (presetn && led_en_r && stack_status.self_test
        |=> network_status_led.red != network_status_led.green)
        else $error("Network LED not alternating in self-test");
    a_ns_noip_off: assert property (!stack_status.self_test && !stack_status.ip_valid
        |=> network_status_led == asle_duo_t'{red: 1'b0, green: 1'b0})
        else $error("Network LED lit without an address");
    a_link_follow: assert property ($past(presetn, 3) && $past(presetn, 2) && $past(presetn)
        && led_en_r && $past(led_en_r) |-> port_link_led == $past(phy_link, 3))
        else $error("Link LED does not follow the link pin");
    a_act_dark_idle: assert property (!act_show_r && !act_sync_r[1] |=> !port_activity_led)
        else $error("Activity LED lit without activity");
    a_apb_one_wait: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("APB answer not exactly one cycle after setup");
    a_irq_level: assert property (irq == |(int_stat_r & int_mask_r))
        else $error("Interrupt output disagrees with masked status");

    c_selftest_end: cover property (stack_status.self_test ##1 !stack_status.self_test);
    c_tmo_clear: cover property (tmo_active ##1 !tmo_active);
    c_irq_raise: cover property (!irq ##1 irq);
    c_act_blink: cover property (port_activity_led ##1 !port_activity_led);

endmodule // asle_top

// file: tb/asle_panel_model.sv
module asle_panel_model (
    input wire logic pclk,
    input wire logic clr,
    input asle_pkg::asle_duo_t ms,
    input asle_pkg::asle_duo_t ns,
    input wire logic link,
    input wire logic act,
    output logic [5:0][7:0] cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    import asle_pkg::*;
    logic [5:0] lit;

    // Lamp order: module green/red, network green/red, link, activity
    assign lit = {act, link, ns.red, ns.green, ms.red, ms.green};

    // Each lamp integrates its glow time; a flash shows as a partial count
    always_ff @(posedge pclk) begin
        for (int i = 0; i < 6; i++) begin
            cnt[i] <= clr ? 8'h00 : cnt[i] + {7'h00, lit[i]};
        end
    end
endmodule // asle_panel_model

// file: tb/asle_top_test.sv
module asle_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import asle_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 0;
    logic phy_link = 0, phy_activity = 0, pready, pslverr, port_link_led, port_activity_led, irq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    asle_stack_t stack_status = '0;
    asle_duo_t module_status_led, network_status_led;
    logic [5:0][7:0] cnt;
    int err_count = 0, check_count = 0;
    logic e;

    always #5 pclk = ~pclk;

    asle_top #(.FLASH_HALF_CYC(8), .ACT_HALF_CYC(4), .TMO_CNT_W(4)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .stack_status(stack_status), .phy_link(phy_link),
        .phy_activity(phy_activity), .module_status_led(module_status_led),
        .network_status_led(network_status_led), .port_link_led(port_link_led),
        .port_activity_led(port_activity_led), .irq(irq));

    asle_panel_model panel_u (.pclk(pclk), .clr(clr), .ms(module_status_led), .ns(network_status_led),
        .link(port_link_led), .act(port_activity_led), .cnt(cnt));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One APB transfer; the request holds until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic er);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 20);
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // A slave that never answers ends the run as a failure
        if (!pready) begin
            err_count++;
            give_verdict();
        end
    endtask

    // Watch the lamps for 32 cycles and name the pattern seen
    task automatic observe(output logic [2:0] ms, output logic [2:0] ns);
        @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (32) @(posedge pclk);
        @(negedge pclk);
        ms = mode_of(cnt[0], cnt[1]);
        ns = mode_of(cnt[2], cnt[3]);
    endtask

    function automatic logic [2:0] mode_of(input logic [7:0] g, input logic [7:0] r);
        if (g == 32 && r == 0) return MODE_GRN_ON;
        if (g == 0 && r == 32) return MODE_RED_ON;
        if (g == 0 && r == 0) return MODE_OFF;
        if (r == 0) return MODE_GRN_FL;
        if (g == 0) return MODE_RED_FL;
        if (g + r == 32) return MODE_ALT;
        return 3'h7;
    endfunction

    task automatic pulse(input logic [9:0] v, input logic [9:0] p);
        @(posedge pclk);
        stack_status <= v | p;
        @(posedge pclk);
        stack_status <= v;
    endtask

    // Every indication mode of both two-colour lamps except the network timeout flash, with priorities
    task automatic test_modes();
        logic [9:0] st [7] = '{10'h114, 10'h010, 10'h180, 10'h158, 10'h134, 10'h298, 10'h11C};
        logic [2:0] em [7] = '{MODE_GRN_ON, MODE_GRN_FL, MODE_RED_ON, MODE_RED_FL, MODE_RED_FL, MODE_ALT,
            MODE_GRN_ON};
        logic [2:0] en [7] = '{MODE_GRN_ON, MODE_GRN_FL, MODE_OFF, MODE_RED_ON, MODE_GRN_ON, MODE_ALT,
            MODE_RED_ON};
        logic [2:0] ms, ns;
        for (int i = 0; i < 7; i++) begin
            @(posedge pclk);
            stack_status <= st[i];
            observe(ms, ns);
            check({29'h0, ms}, {29'h0, em[i]});
            check({29'h0, ns}, {29'h0, en[i]});
        end
        $display("test_modes done");
    endtask

    // Timeout holds until every timed-out connection returns, or reset
    task automatic test_timeout();
        logic [2:0] ms, ns;
        pulse(10'h114, 10'h002);
        pulse(10'h114, 10'h002);
        pulse(10'h110, 10'h001);
        observe(ms, ns);
        check({29'h0, ns}, {29'h0, MODE_RED_FL});
        pulse(10'h110, 10'h001);
        observe(ms, ns);
        check({29'h0, ns}, {29'h0, MODE_GRN_FL});
        pulse(10'h110, 10'h002);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        observe(ms, ns);
        check({29'h0, ns}, {29'h0, MODE_GRN_FL});
        $display("test_timeout done");
    endtask

    // Link lamp follows the pin, activity lamp flashes only with traffic
    task automatic test_port();
        logic [2:0] ms, ns;
        @(posedge pclk);
        phy_link <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge pclk);
            phy_activity <= i[0];
        end
        observe(ms, ns);
        check({24'h0, cnt[4]}, 32'h0000_0020);
        check({31'h0, cnt[5] > 0 && cnt[5] < 32}, 32'h0000_0001);
        // Drop both pins on an edge and let the blink window drain before looking
        @(posedge pclk);
        phy_link <= 1'b0;
        phy_activity <= 1'b0;
        repeat (16) @(posedge pclk);
        observe(ms, ns);
        check({24'h0, cnt[4]}, 32'h0000_0000);
        check({24'h0, cnt[5]}, 32'h0000_0000);
        $display("test_port done");
    endtask

    // Register access, interrupt raise, mask and clear, lamp enable
    task automatic test_regs();
        logic [2:0] ms, ns;
        apb(1'b0, OFF_CTRL, 32'h0, rd, e);
        check(rd, 32'h0000_0001);
        apb(1'b0, 12'h010, 32'h0, rd, e);
        check({31'h0, e}, 32'h0000_0001);
        apb(1'b1, OFF_STATUS, 32'h0, rd, e);
        check({31'h0, e}, 32'h0000_0000);
        apb(1'b1, OFF_INT_STAT, 32'h0000_001F, rd, e);
        apb(1'b1, OFF_INT_MASK, 32'h0000_0001, rd, e);
        pulse(10'h110, 10'h040);
        repeat (4) @(posedge pclk);
        check({31'h0, irq}, 32'h0000_0000);
        pulse(10'h180, 10'h000);
        repeat (4) @(posedge pclk);
        check({31'h0, irq}, 32'h0000_0001);
        apb(1'b0, OFF_STATUS, 32'h0, rd, e);
        check(rd, {29'h0, MODE_RED_ON});
        apb(1'b1, OFF_INT_STAT, 32'h0000_0001, rd, e);
        repeat (3) @(posedge pclk);
        check({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, OFF_CTRL, 32'h0, rd, e);
        phy_link <= 1'b1;
        observe(ms, ns);
        check({26'h0, ms, ns}, 32'h0000_0000);
        check({16'h0, cnt[5], cnt[4]}, 32'h0000_0000);
        apb(1'b1, OFF_CTRL, 32'h0000_0001, rd, e);
        $display("test_regs done");
    endtask

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        test_modes();
        test_timeout();
        test_port();
        test_regs();
        give_verdict();
    end
endmodule // asle_top_test
